// [hdl/pspc_pkg.sv]
// Constants for the three-unit power-stage waveform controller: register map,
// field positions, reset values and prescaler factors.
// Assumes a byte-wide register port with 6 address bits, 16 bytes per unit.
//
// How it works
// R1: Four 12-bit compare values are checked against the counter each step.
// R2: A match pulses a compare event and sets or clears a waveform part.
// R3: Reset-B also carries a 4-bit fraction driving flank width modulation.
// R4: High bytes go through one shared 8-bit holding byte; low writes commit.
// R5: Software writes the high byte first, then the low byte.
// R6: Fifty-percent mode copies set-B and reset-B into A on reset-B update.
// R7: Autolock buffers writes; update at cycle end if reset-B written last.
// R8: Autolock wins over lock when both are set.
// R9: Lock buffers all compare and output writes until lock is cleared.
// R10: Mode field picks one-ramp, two-ramp, four-ramp or center-aligned.
// R11: Polarity bit clear gives active-low outputs, set gives active-high.
// R12: Clock-select bit picks fast input clock when set, slow when clear.
// R13: Unit 2 bit 0 enables output matrix; polarity then has no effect.
// R14: Prescaler divides by 1, 4, then 16/64 early or 32/256 later.
// R15: Balance bit extends flank modulation to on-time 0 as well; the code does so in one-ramp and two-ramp modes only.
// R16: Async control bits let a selected fault drive outputs combinationally.
// R17: Autorun makes a unit start together with its leading unit.
// R18: Complete-cycle lets a halted unit finish its cycle; ignored as slave.
// R19: Run bit starts the unit and wins over its autorun bit.
// R20: Each unit has fast and slow clock inputs chosen before the prescaler.
// R21: End-of-cycle event fires on counter match with reset-B.

package pspc_pkg;

  localparam int UNITS        = 3;
  localparam int CMP_W        = 12;
  localparam int FRAC_W       = 4;
  localparam int ADDR_W       = 6;

  // Byte offsets inside one unit's 16-byte window
  localparam logic [3:0] OFF_SA_L   = 4'h0;
  localparam logic [3:0] OFF_SA_H   = 4'h1;
  localparam logic [3:0] OFF_RA_L   = 4'h2;
  localparam logic [3:0] OFF_RA_H   = 4'h3;
  localparam logic [3:0] OFF_SB_L   = 4'h4;
  localparam logic [3:0] OFF_SB_H   = 4'h5;
  localparam logic [3:0] OFF_RB_L   = 4'h6;
  localparam logic [3:0] OFF_RB_H   = 4'h7;
  localparam logic [3:0] OFF_CNF    = 4'h8;
  localparam logic [3:0] OFF_CTL    = 4'h9;
  localparam logic [3:0] OFF_SOC    = 4'hA;
  localparam logic [3:0] OFF_STAT   = 4'hB;
  localparam logic [3:0] OFF_CNT_L  = 4'hC;
  localparam logic [3:0] OFF_CNT_H  = 4'hD;
  localparam logic [3:0] OFF_MATRIX = 4'hE;

  // Configuration fields
  localparam int CNF_FIFTY  = 7;
  localparam int CNF_ALOCK  = 6;
  localparam int CNF_LOCK   = 5;
  localparam int CNF_MODE_H = 4;
  localparam int CNF_MODE_L = 3;
  localparam int CNF_POL    = 2;
  localparam int CNF_CLKSEL = 1;
  localparam int CNF_MATRIX = 0;

  // Control fields
  localparam int CTL_PRE_H  = 7;
  localparam int CTL_PRE_L  = 6;
  localparam int CTL_BAL    = 5;
  localparam int CTL_AOC_B  = 4;
  localparam int CTL_AOC_A  = 3;
  localparam int CTL_FOLLOW = 2;
  localparam int CTL_FINISH = 1;
  localparam int CTL_RUN    = 0;

  // Output configuration enables
  localparam int SOC_OE_A   = 0;
  localparam int SOC_OE_B   = 2;

  localparam logic [7:0]  CNF_RESET = 8'h00;
  localparam logic [7:0]  CTL_RESET = 8'h00;
  localparam logic [7:0]  SOC_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'h0000;

  // Prescaler terminal counts (factor minus one)
  localparam logic [7:0] PRE_DIV1    = 8'h00;
  localparam logic [7:0] PRE_DIV4    = 8'h03;
  localparam logic [7:0] PRE_DIV16   = 8'h0F;
  localparam logic [7:0] PRE_DIV64   = 8'h3F;
  localparam logic [7:0] PRE_DIV32   = 8'h1F;
  localparam logic [7:0] PRE_DIV256  = 8'hFF;

  typedef enum logic [1:0] {
    PSPC_ONE_RAMP  = 2'b00,
    PSPC_TWO_RAMP  = 2'b01,
    PSPC_FOUR_RAMP = 2'b10,
    PSPC_CENTER    = 2'b11
  } pspc_mode_type;

endpackage

// [hdl/pspc_top.sv]
// Three waveform units, unit 2 adding the output matrix, with compare, lock, prescaler and run control.
// Assumes the fast and slow input clocks arrive as one-cycle enable pulses on
// clk, and fault inputs are already selected and qualified per part.
`timescale 1ns/1ps

module pspc_top #(
  parameter bit LATE_VARIANT = 1'b1
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [pspc_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                  wdata,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [7:0]                  rdata,
  input  wire logic                        fast_input_clock,
  input  wire logic                        slow_input_clock,
  input  wire logic [2:0]                  fault_a,
  input  wire logic [2:0]                  fault_b,
  output logic      [2:0]                  out_a,
  output logic      [2:0]                  out_b,
  output logic      [2:0]                  oe_a,
  output logic      [2:0]                  oe_b,
  output logic      [11:0]                 compare_match,
  output logic      [2:0]                  end_of_cycle,
  output logic      [2:0]                  unit_running
);

  localparam int CW = pspc_pkg::CMP_W;

  function automatic logic [7:0] pre_limit(input logic [1:0] code, input logic late);
    case (code)
      2'b00:   pre_limit = pspc_pkg::PRE_DIV1;
      2'b01:   pre_limit = pspc_pkg::PRE_DIV4;
      2'b10:   pre_limit = late ? pspc_pkg::PRE_DIV32 : pspc_pkg::PRE_DIV16;
      default: pre_limit = late ? pspc_pkg::PRE_DIV256 : pspc_pkg::PRE_DIV64;
    endcase
  endfunction

  function automatic logic [1:0] last_ramp(input logic [1:0] mode);
    case (mode)
      pspc_pkg::PSPC_TWO_RAMP:  last_ramp = 2'h1;
      pspc_pkg::PSPC_FOUR_RAMP: last_ramp = 2'h3;
      default:                  last_ramp = 2'h0;
    endcase
  endfunction

  logic [7:0] temp_q;
  logic [2:0] run_bit;
  logic [2:0] follow_bit;
  logic [7:0] rd_val [3];

  // R4 shared holding byte, R5 high byte first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      temp_q <= 8'h00;
    end else if (wr_en && addr[0] && addr[5:4] != 2'h3) begin
      if (addr[3:0] <= pspc_pkg::OFF_RB_H) begin
        temp_q <= wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_en && addr[5:4] != 2'h3) begin
      rdata <= rd_val[addr[5:4]];
    end else begin
      rdata <= 8'h00;
    end
  end

  genvar u;
  generate
    for (u = 0; u < pspc_pkg::UNITS; u++) begin : g_unit
      localparam int LEAD  = (u + 2) % 3;
      localparam int LEAD2 = (u + 1) % 3;

      logic [15:0] sa_b, ra_b, sb_b, rb_b;
      logic [15:0] sa_w, ra_w, sb_w, rb_w;
      logic [7:0]  cnf_q, ctl_q, soc_b, soc_w, mtx_b, mtx_w;
      logic        rb_last_q;
      logic [7:0]  pre_q;
      logic [CW-1:0] cnt_q;
      logic        dir_q;
      logic [1:0]  ramp_q;
      logic        hold_q;
      logic        a_late_q;
      logic [3:0]  frac_q;
      logic        running_q;
      logic        wa_q, wb_q;
      logic        oa_q, ob_q;
      logic [3:0]  cm_q;
      logic        eoc_q;

      logic        wr_u;
      logic [1:0]  mode;
      logic        center, src_en, step, go, upd;
      logic [CW-1:0] top;
      logic        is_last, at_top, at_bot, stretch, eoc_ev, cyc_end;
      logic        m_sa, m_ra, m_sb, m_rb;
      logic [4:0]  frac_sum;
      logic        carry, matrix_on, a_lvl, b_lvl, inact;

      assign wr_u      = wr_en && addr[5:4] == 2'(u);
      assign mode      = cnf_q[pspc_pkg::CNF_MODE_H:pspc_pkg::CNF_MODE_L];
      assign center    = mode == pspc_pkg::PSPC_CENTER;
      assign run_bit[u]    = ctl_q[pspc_pkg::CTL_RUN];
      assign follow_bit[u] = ctl_q[pspc_pkg::CTL_FOLLOW];

      // R12 R20 clock source before prescaler
      assign src_en = cnf_q[pspc_pkg::CNF_CLKSEL] ? fast_input_clock : slow_input_clock;
      // R14 prescaler
      assign step   = running_q && src_en &&
                      pre_q == pre_limit(ctl_q[pspc_pkg::CTL_PRE_H:pspc_pkg::CTL_PRE_L],
                                         LATE_VARIANT);

      // R17 R19 start with leading unit; run wins
      assign go = run_bit[u] ||
                  (follow_bit[u] && (run_bit[LEAD] || (follow_bit[LEAD] && run_bit[LEAD2])));

      // R10 ramp tops per mode
      always_comb begin
        top = rb_w[CW-1:0];
        if (mode == pspc_pkg::PSPC_TWO_RAMP && ramp_q == 2'h0) begin
          top = ra_w[CW-1:0];
        end else if (mode == pspc_pkg::PSPC_FOUR_RAMP) begin
          case (ramp_q)
            2'h0:    top = sa_w[CW-1:0];
            2'h1:    top = ra_w[CW-1:0];
            2'h2:    top = sb_w[CW-1:0];
            default: top = rb_w[CW-1:0];
          endcase
        end
      end

      assign is_last  = ramp_q == last_ramp(mode);
      assign at_top   = cnt_q == top;
      assign at_bot   = cnt_q == '0;
      // R3 fractional accumulator carry
      assign frac_sum = {1'b0, frac_q} + {1'b0, rb_w[15:12]};
      assign carry    = frac_sum[4];
      assign stretch  = carry && !hold_q;
      // R1 compare every step
      assign m_sa     = step && cnt_q == sa_w[CW-1:0];
      assign m_ra     = step && cnt_q == ra_w[CW-1:0];
      assign m_sb     = step && cnt_q == sb_w[CW-1:0];
      assign m_rb     = step && cnt_q == rb_w[CW-1:0];
      // R21 end of cycle on reset-B match
      assign eoc_ev   = m_rb && at_top && (center ? !dir_q : is_last) && !stretch;
      assign cyc_end  = center ? (step && dir_q && at_bot) : eoc_ev;

      // R8 autolock first, R7 update at cycle end, R9 lock release
      assign upd = cnf_q[pspc_pkg::CNF_ALOCK] ? (cyc_end && rb_last_q)
                                              : !cnf_q[pspc_pkg::CNF_LOCK];

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sa_b      <= pspc_pkg::CMP_RESET;
          ra_b      <= pspc_pkg::CMP_RESET;
          sb_b      <= pspc_pkg::CMP_RESET;
          rb_b      <= pspc_pkg::CMP_RESET;
          cnf_q     <= pspc_pkg::CNF_RESET;
          ctl_q     <= pspc_pkg::CTL_RESET;
          soc_b     <= pspc_pkg::SOC_RESET;
          mtx_b     <= 8'h00;
          rb_last_q <= 1'b0;
        end else begin
          if (upd) begin
            rb_last_q <= 1'b0;
          end
          if (wr_u) begin
            case (addr[3:0])
              // R4 low-byte write commits both bytes
              pspc_pkg::OFF_SA_L: begin
                sa_b      <= {temp_q, wdata};
                rb_last_q <= 1'b0;
              end
              pspc_pkg::OFF_RA_L: begin
                ra_b      <= {temp_q, wdata};
                rb_last_q <= 1'b0;
              end
              pspc_pkg::OFF_SB_L: begin
                sb_b      <= {temp_q, wdata};
                rb_last_q <= 1'b0;
              end
              pspc_pkg::OFF_RB_L: begin
                rb_b      <= {temp_q, wdata};
                rb_last_q <= 1'b1;
                // R6 duplicate B values into A
                if (cnf_q[pspc_pkg::CNF_FIFTY]) begin
                  sa_b <= sb_b;
                  ra_b <= {temp_q, wdata};
                end
              end
              pspc_pkg::OFF_CNF: cnf_q <= (u == 2) ? wdata : {wdata[7:1], 1'b0};
              pspc_pkg::OFF_CTL: ctl_q <= wdata;
              pspc_pkg::OFF_SOC: begin
                soc_b     <= wdata;
                rb_last_q <= 1'b0;
              end
              pspc_pkg::OFF_MATRIX: begin
                if (u == 2) begin
                  mtx_b     <= wdata;
                  rb_last_q <= 1'b0;
                end
              end
              default: ;
            endcase
          end
        end
      end

      // R7 R9 working copies follow buffers only when allowed
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sa_w  <= pspc_pkg::CMP_RESET;
          ra_w  <= pspc_pkg::CMP_RESET;
          sb_w  <= pspc_pkg::CMP_RESET;
          rb_w  <= pspc_pkg::CMP_RESET;
          soc_w <= pspc_pkg::SOC_RESET;
          mtx_w <= 8'h00;
        end else if (upd) begin
          sa_w  <= sa_b;
          ra_w  <= ra_b;
          sb_w  <= sb_b;
          rb_w  <= rb_b;
          soc_w <= soc_b;
          mtx_w <= mtx_b;
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pre_q <= 8'h00;
        end else if (!running_q) begin
          pre_q <= 8'h00;
        end else if (src_en) begin
          pre_q <= step ? 8'h00 : pre_q + 8'h01;
        end
      end

      // R18 finish cycle unless slave
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          running_q <= 1'b0;
        end else if (go) begin
          running_q <= 1'b1;
        end else if (!(ctl_q[pspc_pkg::CTL_FINISH] && !follow_bit[u]) || cyc_end) begin
          running_q <= 1'b0;
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cnt_q  <= '0;
          dir_q  <= 1'b0;
          ramp_q <= 2'h0;
          hold_q <= 1'b0;
          frac_q <= 4'h0;
        end else if (!running_q) begin
          cnt_q  <= '0;
          dir_q  <= 1'b0;
          ramp_q <= 2'h0;
          hold_q <= 1'b0;
        end else if (step) begin
          // R3 carry stretches the top by one step
          if (at_top && (center ? !dir_q : is_last) && stretch) begin
            hold_q <= 1'b1;
          end else if (center) begin
            hold_q <= 1'b0;
            if (!dir_q) begin
              if (at_top) begin
                dir_q <= 1'b1;
              end else begin
                cnt_q <= cnt_q + 1'b1;
              end
            end else if (at_bot) begin
              dir_q <= 1'b0;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end else if (at_top) begin
            hold_q <= 1'b0;
            cnt_q  <= '0;
            ramp_q <= is_last ? 2'h0 : ramp_q + 2'h1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
          if (cyc_end) begin
            frac_q <= frac_sum[3:0];
          end
        end
      end

      // R2 matches set and clear waveform parts
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          wa_q     <= 1'b0;
          wb_q     <= 1'b0;
          a_late_q <= 1'b0;
        end else if (!running_q) begin
          wa_q     <= 1'b0;
          wb_q     <= 1'b0;
          a_late_q <= 1'b0;
        end else if (step) begin
          a_late_q <= 1'b0;
          if (a_late_q) begin
            wa_q <= 1'b0;
          end
          unique case (mode)
            pspc_pkg::PSPC_ONE_RAMP, pspc_pkg::PSPC_TWO_RAMP: begin
              if (m_sa && ramp_q == 2'h0) begin
                wa_q <= 1'b1;
              end
              if (m_ra && ramp_q == 2'h0) begin
                // R15 balanced mode stretches on-time 0 too
                if (ctl_q[pspc_pkg::CTL_BAL] && carry) begin
                  a_late_q <= 1'b1;
                end else begin
                  wa_q <= 1'b0;
                end
              end
              if (m_sb && ramp_q == last_ramp(mode)) begin
                wb_q <= 1'b1;
              end
            end
            pspc_pkg::PSPC_FOUR_RAMP: begin
              if (at_top && ramp_q == 2'h0) begin
                wa_q <= 1'b1;
              end
              if (at_top && ramp_q == 2'h1) begin
                wa_q <= 1'b0;
              end
              if (at_top && ramp_q == 2'h2) begin
                wb_q <= 1'b1;
              end
            end
            pspc_pkg::PSPC_CENTER: begin
              if (m_sa) begin
                wa_q <= !dir_q;
              end
              if (m_sb) begin
                wb_q <= !dir_q;
              end
            end
          endcase
          if (eoc_ev && !center) begin
            wb_q <= 1'b0;
          end
        end
      end

      // R13 matrix on unit 2 overrides polarity
      assign matrix_on = (u == 2) && cnf_q[pspc_pkg::CNF_MATRIX];
      // R11 polarity
      assign a_lvl = matrix_on ? mtx_w[ramp_q] : (cnf_q[pspc_pkg::CNF_POL] ? wa_q : !wa_q);
      assign b_lvl = matrix_on ? mtx_w[4 + ramp_q] : (cnf_q[pspc_pkg::CNF_POL] ? wb_q : !wb_q);
      assign inact = matrix_on ? 1'b0 : !cnf_q[pspc_pkg::CNF_POL];

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          oa_q  <= 1'b0;
          ob_q  <= 1'b0;
          cm_q  <= 4'h0;
          eoc_q <= 1'b0;
        end else begin
          oa_q  <= a_lvl;
          ob_q  <= b_lvl;
          cm_q  <= {m_rb, m_sb, m_ra, m_sa};
          eoc_q <= eoc_ev;
        end
      end

      // R16 fault acts without the clocked path
      assign out_a[u] = (ctl_q[pspc_pkg::CTL_AOC_A] && fault_a[u]) ? inact : oa_q;
      assign out_b[u] = (ctl_q[pspc_pkg::CTL_AOC_B] && fault_b[u]) ? inact : ob_q;
      assign oe_a[u]  = soc_w[pspc_pkg::SOC_OE_A];
      assign oe_b[u]  = soc_w[pspc_pkg::SOC_OE_B];
      assign compare_match[4*u +: 4] = cm_q;
      assign end_of_cycle[u] = eoc_q;
      assign unit_running[u] = running_q;

      // Compare registers are write-only and read as zero
      always_comb begin
        case (addr[3:0])
          pspc_pkg::OFF_CNF:    rd_val[u] = cnf_q;
          pspc_pkg::OFF_CTL:    rd_val[u] = ctl_q;
          pspc_pkg::OFF_SOC:    rd_val[u] = soc_b;
          pspc_pkg::OFF_STAT:   rd_val[u] = {3'h0, rb_last_q, ramp_q, dir_q, running_q};
          pspc_pkg::OFF_CNT_L:  rd_val[u] = cnt_q[7:0];
          pspc_pkg::OFF_CNT_H:  rd_val[u] = {4'h0, cnt_q[CW-1:8]};
          pspc_pkg::OFF_MATRIX: rd_val[u] = (u == 2) ? mtx_b : 8'h00;
          default:              rd_val[u] = 8'h00;
        endcase
      end
    end
  endgenerate

endmodule // pspc_top

// [testbench/pspc_gate_model.sv]
// Gate driver and switch model: latches a fault on a switch that is on.
// Assumes the bench requests trips; LAT delays the answer by clk cycles.
`timescale 1ns/1ps
module pspc_gate_model #(
  parameter int LAT = 0
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] out_a,
  input  wire logic [2:0] out_b,
  input  wire logic [2:0] oe_a,
  input  wire logic [2:0] oe_b,
  input  wire logic [5:0] trip,
  output logic      [2:0] fault_a,
  output logic      [2:0] fault_b
);
  logic [5:0] pipe_q [4];
  // Self-latched, so the forced-off output cannot clear its own fault
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pipe_q <= '{default: 6'h00};
    end else begin
      pipe_q[0] <= trip & (pipe_q[0] | ({oe_b, oe_a} & {out_b, out_a}));
      for (int i = 1; i < 4; i++) begin
        pipe_q[i] <= pipe_q[i - 1];
      end
    end
  end
  assign {fault_b, fault_a} = pipe_q[LAT] & trip;
endmodule // pspc_gate_model

// [testbench/pspc_top_assertions.sv]
// Port-level checker for the waveform controller top.
// Assumes one clock domain; bound to the top module after endmodule.
`timescale 1ns/1ps
module pspc_checker (
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic [pspc_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0]                  wdata,
  input wire logic                        wr_en,
  input wire logic                        rd_en,
  input wire logic [7:0]                  rdata,
  input wire logic                        fast_input_clock,
  input wire logic                        slow_input_clock,
  input wire logic [11:0]                 compare_match,
  input wire logic [2:0]                  end_of_cycle,
  input wire logic [2:0]                  unit_running
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rdata_idle; !$past(rd_en) |-> rdata == 8'h00; endproperty
  property p_cmp_unread; rd_en && !addr[3] |=> rdata == 8'h00; endproperty
  property p_unmapped; rd_en && addr[5:4] == 2'b11 |=> rdata == 8'h00; endproperty
  property p_eoc_match;
    (end_of_cycle & ~{compare_match[11], compare_match[7], compare_match[3]}) == 3'b000;
  endproperty
  property p_eoc_running; (end_of_cycle & ~$past(unit_running)) == 3'b000; endproperty
  property p_idle_quiet; !unit_running[0] |=> compare_match[3:0] == 4'h0; endproperty
  property p_no_source;
    !fast_input_clock && !slow_input_clock |=> end_of_cycle == 3'b000 && compare_match == 12'h000;
  endproperty
  property p_run_start; wr_en && addr == 6'h09 && wdata[0] |-> ##[1:2] unit_running[0];
  endproperty
  property p_halt; wr_en && addr == 6'h19 && wdata[2:0] == 3'b000 |-> ##[1:3] !unit_running[1];
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");
  a_cmp_unread: assert property (p_cmp_unread)
    else $error("compare register readable");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_eoc_match: assert property (p_eoc_match)
    else $error("end of cycle without reset-B match");
  a_eoc_running: assert property (p_eoc_running)
    else $error("end of cycle on a stopped unit");
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("compare match on a stopped unit");
  a_no_source: assert property (p_no_source)
    else $error("counter stepped without a source pulse");
  a_run_start: assert property (p_run_start)
    else $error("unit 0 did not start");
  a_halt: assert property (p_halt)
    else $error("unit 1 did not halt");
  c_eoc: cover property (end_of_cycle[0]);
  c_follow: cover property (unit_running[1]);
  c_match: cover property (compare_match[0]);
endmodule // pspc_checker

bind pspc_top pspc_checker u_pspc_checker (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata(rdata), .fast_input_clock(fast_input_clock), .slow_input_clock(slow_input_clock),
  .compare_match(compare_match), .end_of_cycle(end_of_cycle), .unit_running(unit_running)
);

// [testbench/test_power_stage_pwm_control.sv]
// Self-checking bench for the three-unit waveform controller.
// Assumes the gate model beside it and the register port timing of the design.
`timescale 1ns/1ps
module test_power_stage_pwm_control;
  logic        clk, rst, wr_en, rd_en, fast_on, slow_on, fast_input_clock, slow_input_clock;
  logic [5:0]  addr, trip;
  logic [7:0]  wdata, rdata, v;
  logic [7:0]  cnf_m [3];
  logic [2:0]  fault_a, fault_b, out_a, out_b, oe_a, oe_b, end_of_cycle, unit_running;
  logic [11:0] compare_match;
  int          fail_count, comparisons, t, n, u;

  pspc_top #(.LATE_VARIANT(1'b1)) u_dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .fast_input_clock(fast_input_clock), .slow_input_clock(slow_input_clock),
    .fault_a(fault_a), .fault_b(fault_b), .out_a(out_a), .out_b(out_b), .oe_a(oe_a),
    .oe_b(oe_b), .compare_match(compare_match), .end_of_cycle(end_of_cycle),
    .unit_running(unit_running));
  pspc_gate_model #(.LAT(0)) u_gate (.clk(clk), .rst(rst), .out_a(out_a), .out_b(out_b),
    .oe_a(oe_a), .oe_b(oe_b), .trip(trip), .fault_a(fault_a), .fault_b(fault_b));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    fast_input_clock <= fast_on;
    // Slow source pulses every other cycle
    slow_input_clock <= slow_on & ~slow_input_clock;
  end

  function automatic logic [5:0] ra(input int un, input logic [3:0] off);
    return {2'(un), off};
  endfunction
  // Cycle length: steps per cycle times prescaler factor times source spacing
  function automatic int exp_per(input int rb, input int code, input int src);
    int div [4] = '{1, 4, 32, 256};
    return (rb + 1) * div[code] * src;
  endfunction
  task automatic conclude();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic wr16(input logic [3:0] off, input logic [15:0] val);
    wr(ra(0, off + 4'h1), val[15:8]);
    wr(ra(0, off), val[7:0]);
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic eoc();
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (end_of_cycle[0] !== 1'b1 && t < 6000);
    if (t >= 6000) begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic per(input int exp, input int skip);
    repeat (skip) eoc();
    eoc();
    check("cycle length", 16'(exp), 16'(t));
  endtask
  task automatic hi(input int exp);
    eoc();
    n = 0;
    repeat (10) begin
      @(negedge clk);
      n += int'(out_a[0] === 1'b1);
    end
    check("part A on-time", 16'(exp), 16'(n));
  endtask

  initial begin
    rst = 1'b1;
    {wr_en, rd_en, fast_on, slow_on, fast_input_clock, slow_input_clock} = 6'h00;
    {addr, wdata, trip} = 20'h00000;
    v = 8'($urandom(32'hFFDE));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      rd(ra(k / 2, 4'(8 + k % 2)));
      check("reset value", 16'h0000, 16'(v));
    end
    for (int m = 0; m < 4; m++) begin
      u = m % 3;
      cnf_m[u] = 8'(($urandom & 32'hE7) | (m << 3));
      wr(ra(u, 4'h8), cnf_m[u]);
      wr(ra(u, 4'h9), 8'($urandom & 32'hF8));
      if (u < 2) cnf_m[u][0] = 1'b0;
      rd(ra(u, 4'h8));
      check("configuration", 16'(cnf_m[u]), 16'(v));
    end
    wr(6'h38, 8'hFF);
    rd(6'h38);
    check("unmapped read", 16'h0000, 16'(v));
    for (int k = 0; k < 6; k++) wr(ra(k / 2, 4'(8 + k % 2)), 8'h00);
    fast_on <= 1'b1;
    wr16(4'h0, 16'h0002);
    wr16(4'h2, 16'h0005);
    wr16(4'h4, 16'h0006);
    wr16(4'h6, 16'h0009);
    wr(6'h0A, 8'h05);
    wr(6'h08, 8'h06);
    check("output enables", 16'h0003, 16'({oe_b[0], oe_a[0]}));
    wr(6'h09, 8'h01);
    per(exp_per(9, 0, 1), 1);
    for (int c = 1; c < 4; c++) begin
      wr(6'h09, 8'((c << 6) | 1));
      per(exp_per(9, c, 1), 1);
    end
    wr(6'h09, 8'h01);
    slow_on <= 1'b1;
    wr(6'h08, 8'h04);
    per(exp_per(9, 0, 2), 1);
    wr(6'h08, 8'h06);
    slow_on <= 1'b0;
    hi(3);
    wr(6'h08, 8'h02);
    hi(7);
    wr16(4'h6, 16'hF009);
    per(11, 2);
    wr16(4'h6, 16'h0009);
    for (int m = 1; m < 4; m++) begin
      wr(6'h08, 8'((m << 3) | 6));
      per(m == 1 ? 16 : (m == 2 ? 26 : 20), 1);
    end
    wr(6'h08, 8'h86);
    wr16(4'h6, 16'h0009);
    repeat (2) eoc();
    repeat (20) begin
      @(negedge clk);
      check("fifty percent parts", 16'(out_b[0]), 16'(out_a[0]));
    end
    wr(6'h08, 8'h26);
    wr16(4'h6, 16'h0013);
    per(10, 1);
    wr(6'h08, 8'h06);
    per(20, 1);
    wr(6'h08, 8'h66);
    wr16(4'h6, 16'h0009);
    per(10, 1);
    wr16(4'h6, 16'h0013);
    wr16(4'h0, 16'h0002);
    per(10, 2);
    wr(6'h08, 8'h06);
    wr(6'h07, 8'h00);
    // Another unit's high-byte write replaces the shared holding byte
    wr(6'h11, 8'h01);
    wr(6'h06, 8'h09);
    per(exp_per(265, 0, 1), 1);
    wr(6'h09, 8'h09);
    n = 0;
    while (compare_match[0] !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    if (n >= 600) begin
      fail_count++;
      conclude();
    end
    @(posedge clk);
    trip <= 6'h01;
    @(posedge clk);
    @(negedge clk);
    check("fault raised", 16'h0001, 16'(fault_a[0]));
    check("part A under fault", 16'h0000, 16'(out_a[0]));
    @(posedge clk);
    trip <= 6'h00;
    wr(6'h19, 8'h04);
    repeat (3) @(posedge clk);
    #1 check("follower running", 16'h0001, 16'(unit_running[1]));
    wr(6'h29, 8'h05);
    repeat (3) @(posedge clk);
    #1 check("run bit start", 16'h0001, 16'(unit_running[2]));
    wr(6'h19, 8'h00);
    wr(6'h29, 8'h00);
    wr(6'h09, 8'h02);
    repeat (3) @(posedge clk);
    #1 check("finishing cycle", 16'h0001, 16'(unit_running[0]));
    eoc();
    repeat (4) @(posedge clk);
    #1 check("halted at cycle end", 16'h0000, 16'(unit_running[0]));
    conclude();
  end
endmodule // test_power_stage_pwm_control
